// file: rtl/tpw_map.svh
`ifndef TPW_MAP_SVH
`define TPW_MAP_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define TPW_IDX_MASK1     14'h0013
`define TPW_IDX_PEND1     14'h0014
`define TPW_IDX_PIMASK    14'h1fbc
`define TPW_IDX_PIPEND    14'h1fbe
`define TPW_IDX_OUTCFG    14'h1fc0
`define TPW_IDX_CMP1      14'h1fc2
`define TPW_IDX_CMP2      14'h1fc4
`define TPW_IDX_CMP3      14'h1fc6
`define TPW_IDX_RELOAD    14'h1fc8
`define TPW_IDX_COUNT     14'h1fca
`define TPW_IDX_CONTROL   14'h1fcc
`define TPW_IDX_PROTECT   14'h1fce

// ****************************************************************
// Field positions
// ****************************************************************
`define TPW_CTL_DEAD_LSB  0
`define TPW_CTL_DEAD_MSB  9
`define TPW_CTL_ENABLE    11
`define TPW_CTL_EDGE      12
`define TPW_CTL_DIRUP     15
`define TPW_OUT_POL       6
`define TPW_OUT_GPIO_LSB  8
`define TPW_OUT_SYNC      14
`define TPW_PR_PROTEN     0
`define TPW_PR_OUTEN      1
`define TPW_PR_EDGE       2
`define TPW_PR_POL        3
`define TPW_PR_PULLUP     4
`define TPW_M1_FAULT      0
`define TPW_M1_MUXEN      1
`define TPW_PI_GEN        0

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define TPW_RST16         16'h0000
`define TPW_RST8          8'h00
`define TPW_CNT_ONE       16'h0001
`define TPW_CLK_HZ        250000000
`define TPW_EDGE_MAX_HZ   31250
`define TPW_CTR_MAX_HZ    15625
`define TPW_MIN_RELOAD_EDGE (`TPW_CLK_HZ / `TPW_EDGE_MAX_HZ)
`define TPW_MIN_RELOAD_CTR  (`TPW_CLK_HZ / (2 * `TPW_CTR_MAX_HZ))

`endif

// file: rtl/tpw_pkg.sv
package tpw_pkg;
    // Timebase sequencer states
    typedef enum logic [1:0] {
        TPW_IDLE,
        TPW_UP,
        TPW_DOWN,
        TPW_TURN
    } tpw_state_t;
endpackage

// file: rtl/tpw_wave_gen.sv
`timescale 1ns/100ps
`include "tpw_map.svh"

module tpw_wave_gen import tpw_pkg::*; #(
    parameter logic [15:0] MIN_RELOAD_EDGE = 16'(`TPW_MIN_RELOAD_EDGE),
    parameter logic [15:0] MIN_RELOAD_CTR  = 16'(`TPW_MIN_RELOAD_CTR)
) (
    input  wire logic        clk_sys,             // System clock, one state per edge
    input  wire logic        rst,                 // Synchronous reset, active high
    input  wire logic [15:0] address,             // Avalon byte address
    input  wire logic        read,                // Avalon read
    input  wire logic        write,               // Avalon write
    input  wire logic [31:0] writedata,           // Avalon write data
    input  wire logic [3:0]  byteenable,          // Avalon byte lanes
    output logic      [31:0] readdata,            // Avalon read data
    output logic             waitrequest,         // Avalon stall
    input  wire logic        external_fault_input, // Asynchronous fault pin
    output logic             phase1_positive_out, // Phase 1 high side
    output logic             phase1_negative_out, // Phase 1 low side
    output logic             phase2_positive_out, // Phase 2 high side
    output logic             phase2_negative_out, // Phase 2 low side
    output logic             phase3_positive_out, // Phase 3 high side
    output logic             phase3_negative_out, // Phase 3 low side
    output logic      [5:0]  pinOeN,              // Pin drive enable, low drives
    output logic             pinPullUp,           // Weak pull-ups applied
    output logic             irqFault,            // Fault interrupt request
    output logic             irqPeripheral        // Muxed peripheral request
);

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic        ack_q;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic [13:0] idx;
    logic        wrEn;
    logic        rdReq;

    // One wait state: data and side effects land on the acked edge
    assign idx         = address[15:2];
    assign waitrequest = (read | write) & ~ack_q;
    assign wrEn        = write & ack_q;
    assign rdReq       = read & ~ack_q;
    assign readdata    = rdData_q;

    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0]  mask1_q, pend1_q, piMask_q, piPend_q;
    logic [7:0]  mask1_d, pend1_d, piMask_d, piPend_d;
    logic [15:0] outBuf_q, outAct_q, relBuf_q, relAct_q, ctl_q, prot_q;
    logic [15:0] outBuf_d, outAct_d, relBuf_d, relAct_d, ctl_d, prot_d;
    logic [15:0] cmpBuf_q [3];
    logic [15:0] cmpAct_q [3];
    logic [15:0] cnt_q, cnt_d;
    tpw_state_t  state_q, state_d;
    logic        periodEvt;
    logic        faultEvt;
    logic        running;
    logic        stopped;
    logic [15:0] effReload;
    logic [15:0] minReload;
    logic        edgeMode;
    logic [9:0]  deadTime;
    logic        outEn;
    logic        dirUp;
    logic [7:0]  pend1View;

    assign edgeMode  = ctl_q[`TPW_CTL_EDGE];
    assign deadTime  = ctl_q[`TPW_CTL_DEAD_MSB:`TPW_CTL_DEAD_LSB];
    assign outEn     = prot_q[`TPW_PR_OUTEN];
    assign running   = ctl_q[`TPW_CTL_ENABLE] & (relAct_q != `TPW_RST16);
    assign stopped   = ~running | (state_q == TPW_IDLE);
    assign minReload = edgeMode ? MIN_RELOAD_EDGE : MIN_RELOAD_CTR;
    // Short reloads are stretched so the carrier cannot exceed its ceiling
    assign effReload = (relAct_q < minReload) ? minReload : relAct_q;
    assign dirUp     = (state_q == TPW_UP) | (state_q == TPW_TURN);
    assign pend1View = {pend1_q[7:2], |(piPend_q & piMask_q), pend1_q[0]};

    // Software-visible registers; hardware sets beat software clears
    always_comb begin
        mask1_d  = mask1_q;
        piMask_d = piMask_q;
        outBuf_d = outBuf_q;
        relBuf_d = relBuf_q;
        ctl_d    = ctl_q;
        prot_d   = prot_q;
        pend1_d  = pend1_q;
        piPend_d = piPend_q;
        if (wrEn && byteenable[0]) begin
            if (idx == `TPW_IDX_MASK1)  mask1_d  = writedata[7:0];
            if (idx == `TPW_IDX_PIMASK) piMask_d = writedata[7:0];
            if (idx == `TPW_IDX_PEND1)  pend1_d  = writedata[7:0];
            if (idx == `TPW_IDX_PIPEND) piPend_d = writedata[7:0];
        end
        if (wrEn && idx == `TPW_IDX_OUTCFG)  outBuf_d = merge16(outBuf_q, writedata, byteenable);
        if (wrEn && idx == `TPW_IDX_RELOAD)  relBuf_d = merge16(relBuf_q, writedata, byteenable);
        if (wrEn && idx == `TPW_IDX_CONTROL) ctl_d    = merge16(ctl_q, writedata, byteenable);
        if (wrEn && idx == `TPW_IDX_PROTECT) prot_d   = merge16(prot_q, writedata, byteenable);
        ctl_d[`TPW_CTL_DIRUP] = 1'b0;                         // Direction is live, not stored
        if (faultEvt) begin
            prot_d[`TPW_PR_OUTEN] = 1'b0;
            pend1_d[`TPW_M1_FAULT] = 1'b1;
        end
        if (periodEvt) piPend_d[`TPW_PI_GEN] = 1'b1;
        pend1_d[`TPW_M1_MUXEN] = 1'b0;                        // Derived from muxed sources
    end

    // Active copies load at period end or while stopped; the output copy also loads at once while its SYNC bit is clear
    always_comb begin
        relAct_d = relAct_q;
        outAct_d = outAct_q;
        if (stopped || periodEvt) relAct_d = relBuf_q;
        if (!outBuf_q[`TPW_OUT_SYNC] || stopped || periodEvt) outAct_d = outBuf_q;
    end

    // Read mux, sampled in the stall cycle so data stands at the ack edge
    always_comb begin
        rdData_d = 32'h0000_0000;
        case (idx)
            `TPW_IDX_MASK1:   rdData_d[7:0]  = mask1_q;
            `TPW_IDX_PEND1:   rdData_d[7:0]  = pend1View;
            `TPW_IDX_PIMASK:  rdData_d[7:0]  = piMask_q;
            `TPW_IDX_PIPEND:  rdData_d[7:0]  = piPend_q;
            `TPW_IDX_OUTCFG:  rdData_d[15:0] = outBuf_q;
            `TPW_IDX_CMP1:    rdData_d[15:0] = cmpBuf_q[0];
            `TPW_IDX_CMP2:    rdData_d[15:0] = cmpBuf_q[1];
            `TPW_IDX_CMP3:    rdData_d[15:0] = cmpBuf_q[2];
            `TPW_IDX_RELOAD:  rdData_d[15:0] = relBuf_q;
            `TPW_IDX_COUNT:   rdData_d[15:0] = cnt_q;
            `TPW_IDX_CONTROL: rdData_d[15:0] = {dirUp, ctl_q[14:0]};
            `TPW_IDX_PROTECT: rdData_d[15:0] = prot_q;
            default:          rdData_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_q    <= 1'b0;
            rdData_q <= 32'h0000_0000;
        end else begin
            ack_q    <= (read | write) & ~ack_q;
            rdData_q <= rdReq ? rdData_d : rdData_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mask1_q  <= `TPW_RST8;
            pend1_q  <= `TPW_RST8;
            piMask_q <= `TPW_RST8;
            piPend_q <= `TPW_RST8;
            outBuf_q <= `TPW_RST16;
            outAct_q <= `TPW_RST16;
            relBuf_q <= `TPW_RST16;
            relAct_q <= `TPW_RST16;
            ctl_q    <= `TPW_RST16;
            prot_q   <= `TPW_RST16;
        end else begin
            mask1_q  <= mask1_d;
            pend1_q  <= pend1_d;
            piMask_q <= piMask_d;
            piPend_q <= piPend_d;
            outBuf_q <= outBuf_d;
            outAct_q <= outAct_d;
            relBuf_q <= relBuf_d;
            relAct_q <= relAct_d;
            ctl_q    <= ctl_d;
            prot_q   <= prot_d;
        end
    end

    // ****************************************************************
    // Timebase
    // ****************************************************************
    // Edge mode counts 1..reload; centre mode bounces between them
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        periodEvt = 1'b0;
        case (state_q)
            TPW_IDLE: begin
                cnt_d = edgeMode ? `TPW_CNT_ONE : relBuf_q;
                if (running) state_d = edgeMode ? TPW_UP : TPW_DOWN;
            end
            TPW_UP: begin
                if (cnt_q >= effReload) begin
                    periodEvt = 1'b1;
                    cnt_d     = edgeMode ? `TPW_CNT_ONE : cnt_q - `TPW_CNT_ONE;
                    state_d   = edgeMode ? TPW_UP : TPW_DOWN;
                end else begin
                    cnt_d = cnt_q + `TPW_CNT_ONE;
                end
            end
            TPW_DOWN: begin
                if (cnt_q <= `TPW_CNT_ONE) state_d = TPW_TURN;
                else cnt_d = cnt_q - `TPW_CNT_ONE;
            end
            TPW_TURN: begin
                // One state of dwell at the bottom before counting up
                state_d = TPW_UP;
                cnt_d   = cnt_q + `TPW_CNT_ONE;
            end
            default: state_d = TPW_IDLE;
        endcase
        if (!running) state_d = TPW_IDLE;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= TPW_IDLE;
            cnt_q   <= `TPW_RST16;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ****************************************************************
    // Phase channels and dead time
    // ****************************************************************
    logic [2:0]  wfg_q, wfgPrev_q, even, odd;
    logic [9:0]  dtCnt_q [3];
    logic [5:0]  pinRaw;

    for (genvar p = 0; p < 3; p++) begin : g_phase
        logic wfg_d;
        logic match;
        logic dtOk;
        // Each phase compares against its own active compare value
        assign match = (cnt_q == cmpAct_q[p]);
        always_comb begin
            wfg_d = wfg_q[p];
            if (state_q == TPW_IDLE) wfg_d = 1'b0;
            else if (state_q == TPW_TURN || (edgeMode && periodEvt)) wfg_d = 1'b1;
            else if (state_q == TPW_UP && match) wfg_d = 1'b0;
            else if (state_q == TPW_DOWN && match) wfg_d = 1'b1;
        end
        assign dtOk    = (dtCnt_q[p] == 10'h000);
        assign even[p] = wfg_q[p] & dtOk;
        assign odd[p]  = ~wfg_q[p] & dtOk;
        assign pinRaw[2*p]   = odd[p];
        assign pinRaw[2*p+1] = even[p];
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                wfg_q[p]     <= 1'b0;
                wfgPrev_q[p] <= 1'b0;
                dtCnt_q[p]   <= 10'h000;
                cmpBuf_q[p]  <= `TPW_RST16;
                cmpAct_q[p]  <= `TPW_RST16;
            end else begin
                wfg_q[p]     <= wfg_d;
                wfgPrev_q[p] <= wfg_q[p];
                // Reload as the waveform edge is made, so no pin pair switches with zero gap
                if (wfg_d != wfg_q[p]) dtCnt_q[p] <= deadTime;
                else if (!dtOk) dtCnt_q[p] <= dtCnt_q[p] - 10'h001;
                if (wrEn && idx == `TPW_IDX_CMP1 + 14'(2 * p))
                    cmpBuf_q[p] <= merge16(cmpBuf_q[p], writedata, byteenable);
                if (stopped || periodEvt) cmpAct_q[p] <= cmpBuf_q[p];
            end
        end
    end

    // ****************************************************************
    // Protection
    // ****************************************************************
    logic faultS1_q, faultS2_q, faultActPrev_q, faultAct;

    // Level or edge, high or low sense, all chosen in software
    assign faultAct = prot_q[`TPW_PR_POL] ? faultS2_q : ~faultS2_q;
    assign faultEvt = prot_q[`TPW_PR_PROTEN] &
                      (prot_q[`TPW_PR_EDGE] ? (faultAct & ~faultActPrev_q) : faultAct);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            faultS1_q      <= 1'b0;
            faultS2_q      <= 1'b0;
            faultActPrev_q <= 1'b0;
        end else begin
            faultS1_q      <= external_fault_input;
            faultS2_q      <= faultS1_q;
            faultActPrev_q <= faultAct;
        end
    end

    // ****************************************************************
    // Pins and interrupts
    // ****************************************************************
    logic [5:0] pin_q, pin_d, oeN_q, oeN_d;
    logic       pull_q;
    logic       pol;

    assign pol = outAct_q[`TPW_OUT_POL];
    // Unselected pins carry a plain level; disabled ones go inactive or float
    always_comb begin
        for (int j = 0; j < 6; j++) begin
            oeN_d[j] = 1'b0;
            if (!outAct_q[j]) pin_d[j] = outAct_q[`TPW_OUT_GPIO_LSB + j];
            else if (outEn) pin_d[j] = pinRaw[j] ? pol : ~pol;
            else begin
                pin_d[j] = ~pol;
                oeN_d[j] = prot_q[`TPW_PR_PULLUP];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_q  <= 6'h00;
            oeN_q  <= 6'h00;
            pull_q <= 1'b0;
        end else begin
            pin_q  <= pin_d;
            oeN_q  <= oeN_d;
            pull_q <= ~outEn & prot_q[`TPW_PR_PULLUP];
        end
    end

    assign {phase3_positive_out, phase3_negative_out, phase2_positive_out,
            phase2_negative_out, phase1_positive_out, phase1_negative_out} = pin_q;
    assign pinOeN        = oeN_q;
    assign pinPullUp     = pull_q;
    assign irqFault      = pend1_q[`TPW_M1_FAULT] & mask1_q[`TPW_M1_FAULT];
    assign irqPeripheral = pend1View[`TPW_M1_MUXEN] & mask1_q[`TPW_M1_MUXEN];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    dead_gap_a: assert property ((even & odd) == 3'b000 && ($past(deadTime) == 10'h000 ||
        ((even & $past(odd)) | (odd & $past(even))) == 3'b000))
        else $error("complementary phases active together");
    fault_off_a: assert property (faultEvt |=> !outEn ##1 (pinOeN != 6'h00 ||
        !outAct_q[0] || pin_q[0] == ~pol)) else $error("fault did not disable outputs");
    fault_pend_a: assert property (faultEvt |=> pend1_q[`TPW_M1_FAULT])
        else $error("fault pending not set");
    cnt_range_a: assert property (state_q != TPW_IDLE |->
        cnt_q >= `TPW_CNT_ONE && cnt_q <= effReload) else $error("count out of range");
    edge_wrap_a: assert property (edgeMode && periodEvt && running |=>
        cnt_q == `TPW_CNT_ONE && wfg_q == 3'b111) else $error("edge wrap wrong");
    match_clr_a: assert property (state_q == TPW_UP && running && !periodEvt &&
        cnt_q == cmpAct_q[0] |=> !wfg_q[0]) else $error("match did not clear phase");
    dt_load_a: assert property (wfg_q[0] != wfgPrev_q[0] && deadTime != 10'h000 &&
        $stable(deadTime) |-> dtCnt_q[0] == deadTime && !even[0] && !odd[0])
        else $error("dead counter not loaded");
    irq_gate_a: assert property (periodEvt && piMask_q[0] && mask1_q[1] &&
        !wrEn |=> irqPeripheral) else $error("peripheral irq missing");
    ro_count_a: assert property (read && ack_q && idx == `TPW_IDX_COUNT |->
        readdata[15:0] == $past(cnt_q)) else $error("count readback wrong");
    min_rate_a: assert property (periodEvt && running |-> cnt_q >= minReload)
        else $error("carrier above ceiling");

    logic dtOk_any;
    assign dtOk_any = (dtCnt_q[0] == 10'h000);
    fault_seen_c: cover property (faultEvt ##1 !outEn);
    edge_wrap_c: cover property (edgeMode && periodEvt);
    ctr_turn_c: cover property (state_q == TPW_TURN ##1 state_q == TPW_UP);
    dead_run_c: cover property (!dtOk_any ##1 dtOk_any);

endmodule

// file: dv/tpw_switch_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Bridge of power switches behind the six gate pins
// ****************************************************************
module tpw_switch_model (
    input  wire logic       clk_sys,  // System clock
    input  wire logic [5:0] pinLevel, // {p3pos,p3neg,p2pos,p2neg,p1pos,p1neg}
    input  wire logic [5:0] pinOeN,   // Low while the block drives a pin
    input  wire logic       faultReq, // Bench asks for an overcurrent trip
    output logic            faultPin, // Trip line back to the block
    output int              overlaps  // Cycles with a leg shorted
);
    // Trip sense drives the line high; the block chooses which sense counts
    assign faultPin = faultReq;
    // A leg shorts when both gates are on, or one turns on as its partner turns off
    logic [5:0] gateOn, gateOnPrev;
    assign gateOn = pinLevel & ~pinOeN;
    initial begin
        overlaps   = 0;
        gateOnPrev = 6'h00;
    end
    always @(posedge clk_sys) begin
        gateOnPrev <= gateOn;
        for (int j = 0; j < 3; j++) begin
            if (&gateOn[2*j +: 2] || (gateOn[2*j] && gateOnPrev[2*j+1]) ||
                (gateOn[2*j+1] && gateOnPrev[2*j])) begin
                overlaps <= overlaps + 1;
            end
        end
    end
endmodule

// file: dv/three_phase_pwm_waveform_generator_tb_top.sv
`timescale 1ns/100ps
`include "tpw_map.svh"
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module three_phase_pwm_waveform_generator_tb_top import tpw_pkg::*;;
    logic        clk_sys, rst, read, write, faultReq;
    logic [15:0] address, rd, c1, maxCnt, minCnt;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic        sawUp, sawDown;
    wire  [31:0] readdata;
    wire  [5:0]  pinLevel, pinOeN;
    wire         waitrequest, pinPullUp, irqFault, irqPeripheral, faultPin;
    int          miscompares, nChecks, overlaps, seed, h1, h2, h3, lowSum, k;

    // Short counts so a carrier period fits in a few cycles
    tpw_wave_gen #(.MIN_RELOAD_EDGE(16'h0004), .MIN_RELOAD_CTR(16'h0004)) dut (
        .clk_sys(clk_sys), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .external_fault_input(faultPin),
        .phase1_positive_out(pinLevel[1]), .phase1_negative_out(pinLevel[0]),
        .phase2_positive_out(pinLevel[3]), .phase2_negative_out(pinLevel[2]),
        .phase3_positive_out(pinLevel[5]), .phase3_negative_out(pinLevel[4]),
        .pinOeN(pinOeN), .pinPullUp(pinPullUp), .irqFault(irqFault),
        .irqPeripheral(irqPeripheral));
    tpw_switch_model bridge (.clk_sys(clk_sys), .pinLevel(pinLevel), .pinOeN(pinOeN),
        .faultReq(faultReq), .faultPin(faultPin), .overlaps(overlaps));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        $display("Counts: checks=%0d mismatches=%0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One Avalon transfer; request held until waitrequest is sampled low
    task automatic busOp(input logic isRd, input logic [13:0] idx, input logic [15:0] wd);
        int n;
        read <= isRd;
        write <= ~isRd;
        address <= {idx, 2'b00};
        writedata <= {16'h0000, wd};
        byteenable <= 4'h3;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (waitrequest === 1'b0) break;
        end
        if (n == 20) begin
            miscompares++;
            stop_test();
        end
        rd = readdata[15:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [13:0] i, input logic [15:0] d);
        busOp(1'b0, i, d);
    endtask
    task automatic rg(input logic [13:0] i);
        busOp(1'b1, i, 16'h0000);
    endtask
    // High time over two periods, the dead time eating each rising edge
    function automatic logic inBand(int got, int cmp, int dead);
        return (got >= 2 * (cmp - dead) - 4) && (got <= 2 * (cmp - dead) + 4);
    endfunction

    // A hung handshake or wait must still reach the verdict
    initial begin
        repeat (50000) @(posedge clk_sys);
        miscompares++;
        stop_test();
    end

    initial begin
        seed = 72;
        {rst, read, write, faultReq} = 4'h8;
        address = 16'h0000;
        writedata = 32'h0000_0000;
        byteenable = 4'h0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        // ****************************************************************
        // Reset state, read-only counter, buffer readback
        // ****************************************************************
        rg(`TPW_IDX_PROTECT); `CHK(rd, 16'h0000)
        `CHK({pinOeN, irqFault, irqPeripheral}, 8'h00)
        rg(14'h0100); `CHK(rd, 16'h0000)
        wr(`TPW_IDX_COUNT, 16'h1234); rg(`TPW_IDX_COUNT); `CHK(rd, 16'h0000)
        for (int i = 0; i < 3; i++) begin
            c1 = 16'($random(seed));
            wr(`TPW_IDX_CMP1 + 14'(2 * i), c1);
            rg(`TPW_IDX_CMP1 + 14'(2 * i)); `CHK(rd, c1)
        end
        $display("Test registers done");
        // ****************************************************************
        // Carrier cap and count range, then direction in centre mode
        // ****************************************************************
        wr(`TPW_IDX_RELOAD, 16'h0002);
        wr(`TPW_IDX_CONTROL, 16'h1800);
        {maxCnt, minCnt, sawUp, sawDown} = {16'h0000, 16'hffff, 2'b00};
        // Reads land three cycles apart, so every count of a four-state period is seen
        repeat (12) begin
            rg(`TPW_IDX_COUNT);
            if (rd > maxCnt) maxCnt = rd;
            if (rd < minCnt) minCnt = rd;
        end
        `CHK(maxCnt, 16'h0004)
        `CHK(minCnt, 16'h0001)
        wr(`TPW_IDX_CONTROL, 16'h0800);
        repeat (12) begin
            rg(`TPW_IDX_CONTROL);
            sawUp |= rd[15];
            sawDown |= ~rd[15];
        end
        `CHK({sawUp, sawDown}, 2'b11)
        wr(`TPW_IDX_CONTROL, 16'h0000);
        $display("Test timebase done");
        // ****************************************************************
        // Edge-aligned duty per phase with a dead time of three
        // ****************************************************************
        c1 = 16'(4 + ($random(seed) & 7));
        wr(`TPW_IDX_OUTCFG, 16'h007f);
        wr(`TPW_IDX_PROTECT, 16'h0002);
        for (int i = 0; i < 3; i++) wr(`TPW_IDX_CMP1 + 14'(2 * i), c1 + 16'(10 * i));
        wr(`TPW_IDX_RELOAD, 16'h0028);
        wr(`TPW_IDX_CONTROL, 16'h1803);
        repeat (45) @(posedge clk_sys);
        {h1, h2, h3, lowSum} = '0;
        repeat (80) begin
            @(posedge clk_sys);
            h1 += int'(pinLevel[1]);
            h2 += int'(pinLevel[3]);
            h3 += int'(pinLevel[5]);
            lowSum += int'(pinLevel[1:0] == 2'b00);
        end
        `CHK({inBand(h1, c1, 3), inBand(h2, c1 + 10, 3), inBand(h3, c1 + 20, 3)}, 3'b111)
        `CHK((lowSum >= 8) && (lowSum <= 20), 1'b1)
        `CHK(overlaps, 0)
        $display("Test duty done");
        // ****************************************************************
        // Protection: edge trip, level sense, pull-up release
        // ****************************************************************
        wr(`TPW_IDX_MASK1, 16'h0001);
        wr(`TPW_IDX_PROTECT, 16'h000f);
        faultReq <= 1'b1;
        for (k = 0; k < 20 && irqFault !== 1'b1; k++) @(posedge clk_sys);
        `CHK(irqFault, 1'b1)
        @(posedge clk_sys);
        `CHK(pinLevel, 6'h00)
        rg(`TPW_IDX_PROTECT); `CHK(rd[1], 1'b0)
        rg(`TPW_IDX_PEND1); `CHK(rd[0], 1'b1)
        faultReq <= 1'b0;
        wr(`TPW_IDX_MASK1, 16'h0000); `CHK(irqFault, 1'b0)
        wr(`TPW_IDX_PEND1, 16'h0000); rg(`TPW_IDX_PEND1); `CHK(rd[0], 1'b0)
        wr(`TPW_IDX_PROTECT, 16'h000b); rg(`TPW_IDX_PROTECT); `CHK(rd[1], 1'b1)
        faultReq <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rg(`TPW_IDX_PEND1); `CHK(rd[0], 1'b1)
        faultReq <= 1'b0;
        wr(`TPW_IDX_PROTECT, 16'h0010);
        repeat (3) @(posedge clk_sys);
        `CHK({pinPullUp, pinOeN}, 7'h7f)
        wr(`TPW_IDX_PROTECT, 16'h0000);
        repeat (3) @(posedge clk_sys);
        `CHK({pinPullUp, pinOeN}, 7'h00)
        $display("Test protection done");
        // ****************************************************************
        // Muxed peripheral request from the running period
        // ****************************************************************
        wr(`TPW_IDX_PIMASK, 16'h0001);
        wr(`TPW_IDX_MASK1, 16'h0002);
        for (k = 0; k < 100 && irqPeripheral !== 1'b1; k++) @(posedge clk_sys);
        `CHK(irqPeripheral, 1'b1)
        rg(`TPW_IDX_PIPEND); `CHK(rd[0], 1'b1)
        wr(`TPW_IDX_MASK1, 16'h0000); `CHK(irqPeripheral, 1'b0)
        // Unselected pins carry the plain levels of the output register
        wr(`TPW_IDX_OUTCFG, 16'h2a00);
        repeat (2) @(posedge clk_sys);
        `CHK({pinOeN, pinLevel}, 12'h02a)
        $display("Test interrupts done");
        stop_test();
    end
endmodule
